/* core/pacc_defs.svh */
`ifndef PACC_DEFS_SVH
`define PACC_DEFS_SVH

// ----------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------
`define PACC_IDX_MASK2     6'h24
`define PACC_IDX_FLAG2     6'h25
`define PACC_IDX_CTL       6'h26
`define PACC_IDX_CNT       6'h27
`define PACC_IDX_FCLR      6'h28

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PACC_CTL_EN        6
`define PACC_CTL_MODE      5
`define PACC_CTL_EDGE      4
`define PACC_CTL_ICSEL     2
`define PACC_CTL_RTR_LO    0
`define PACC_MASK2_PR_LO   0
`define PACC_MASK2_AUX_LO  6
`define PACC_BIT_OVF       5
`define PACC_BIT_EDGE      4

// ----------------------------------------
// Writable bits and reset values
// ----------------------------------------
`define PACC_CTL_WMASK     8'h77
`define PACC_MASK2_WMASK   8'hf3
`define PACC_CTL_RST       8'h00
`define PACC_MASK2_RST     8'h00

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define PACC_GATE_DIV      256

`endif

/* core/pacc_pkg.sv */
package pacc_pkg;

	// Bus slave handshake states
	typedef enum logic [1:0] {
		PACC_S_IDLE = 2'b01,
		PACC_S_ACK  = 2'b10
	} pacc_bus_state_t;

	// Counting modes
	typedef enum logic {
		PACC_MODE_EVENT = 1'b0,
		PACC_MODE_GATED = 1'b1
	} pacc_mode_t;

endpackage

/* core/pacc_top.sv */
`timescale 1ns/1ps
`include "pacc_defs.svh"

// Contract
// - An 8-bit counter runs as gated time accumulator when mode is 1, as event counter when 0.
// - In event mode it counts falling input edges with edge select 0, rising edges with 1.
// - In gated mode it counts a free-running reference tick divided by 256 while the pin is active.
// - In gated mode edge select 0 makes a low input inhibit counting, 1 makes a high input inhibit.
// - The counter only counts while the enable bit is 1.
// - Software can read or write the count at any time, in any mode.
// - Reset leaves the count alone and clears the control registers and both flags.
// - Increments and software reads never meet on a changing value.
// - Control bits 7 and 3 are unimplemented and read zero.
// - A control bit selects input capture (1) or output compare (0) on the shared channel.
// - Mask bit 5 enables the overflow interrupt, bit 4 the edge interrupt; flags sit in the flag register.
// - The mask register resets to zero, bits 3 and 2 read zero, bits 1 and 0 select the prescaler.
// - Rollover from all ones to zero sets the overflow flag, write 1 to bit 5 clears it, irq when enabled.
// - Each selected pin edge sets the edge flag while the enable bit is 1, write 1 to bit 4 clears it, mask bit 4 never alters setting.

module pacc_top
	import pacc_pkg::*;
#(
	parameter int unsigned GATE_DIV = `PACC_GATE_DIV
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// Avalon-MM slave
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// Accumulator pin
	input  wire logic        accum_input_pin,
	// Timer side controls
	output logic             capture_or_compare_select,
	output logic      [1:0]  prescale_sel,
	output logic      [1:0]  rti_rate_sel,
	output logic      [1:0]  timer_aux_irq_enable,
	// Interrupt
	output logic             irq
);

	localparam int PW = (GATE_DIV < 2) ? 1 : $clog2(GATE_DIV);

	if (GATE_DIV < 2) begin : g_bad_div
		$error("GATE_DIV must be at least 2");
	end

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	pacc_bus_state_t state;
	logic [7:0]      timer_irq_mask_two;
	logic [7:0]      pulse_accum_control;
	logic [7:0]      pulse_count;
	logic            overflow_flag;
	logic            edge_flag;
	logic [31:0]     next_readdata;

	logic            accum_enable;
	pacc_mode_t      accum_mode_select;
	logic            edge_polarity_select;
	logic            overflow_irq_enable;
	logic            edge_irq_enable;

	assign accum_enable         = pulse_accum_control[`PACC_CTL_EN];
	assign accum_mode_select    = pacc_mode_t'(pulse_accum_control[`PACC_CTL_MODE]);
	assign edge_polarity_select = pulse_accum_control[`PACC_CTL_EDGE];
	assign overflow_irq_enable  = timer_irq_mask_two[`PACC_BIT_OVF];
	assign edge_irq_enable      = timer_irq_mask_two[`PACC_BIT_EDGE];

	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	logic       bus_req;
	logic       bus_ack;
	logic [5:0] reg_idx;
	logic       wr_lane;

	assign bus_req     = read | write;
	assign bus_ack     = (state == PACC_S_ACK);
	assign waitrequest = bus_req & ~bus_ack;
	assign reg_idx     = address[7:2];
	assign wr_lane     = write & bus_ack & byteenable[0];

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state <= PACC_S_IDLE;
		end else begin
			unique case (state)
				PACC_S_IDLE: begin
					if (bus_req) begin
						state <= PACC_S_ACK;
					end
				end
				PACC_S_ACK: begin
					state <= PACC_S_IDLE;
				end
			endcase
		end
	end

	logic wr_mask2;
	logic wr_flag2;
	logic wr_ctl;
	logic wr_cnt;
	logic wr_fclr;

	assign wr_mask2 = wr_lane & (reg_idx == `PACC_IDX_MASK2);
	assign wr_flag2 = wr_lane & (reg_idx == `PACC_IDX_FLAG2);
	assign wr_ctl   = wr_lane & (reg_idx == `PACC_IDX_CTL);
	assign wr_cnt   = wr_lane & (reg_idx == `PACC_IDX_CNT);
	assign wr_fclr  = wr_lane & (reg_idx == `PACC_IDX_FCLR);

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always_comb begin
		next_readdata = 32'h0000_0000;
		unique case (reg_idx)
			`PACC_IDX_MASK2: begin
				next_readdata[7:0] = timer_irq_mask_two & `PACC_MASK2_WMASK;
			end
			`PACC_IDX_FLAG2: begin
				next_readdata[`PACC_BIT_OVF]  = overflow_flag;
				next_readdata[`PACC_BIT_EDGE] = edge_flag;
			end
			`PACC_IDX_CTL: begin
				next_readdata[7:0] = pulse_accum_control & `PACC_CTL_WMASK;
			end
			`PACC_IDX_CNT: begin
				next_readdata[7:0] = pulse_count;
			end
			default: begin
				next_readdata = 32'h0000_0000;
			end
		endcase
	end

	// Snapshot in the wait cycle, so the count cannot move under a read
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			readdata <= 32'h0000_0000;
		end else if (read & ~bus_ack) begin
			readdata <= next_readdata;
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pulse_accum_control <= `PACC_CTL_RST;
		end else if (wr_ctl) begin
			pulse_accum_control <= writedata[7:0] & `PACC_CTL_WMASK;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			timer_irq_mask_two <= `PACC_MASK2_RST;
		end else if (wr_mask2) begin
			timer_irq_mask_two <= writedata[7:0] & `PACC_MASK2_WMASK;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			capture_or_compare_select <= 1'b0;
			prescale_sel              <= 2'h0;
			rti_rate_sel              <= 2'h0;
			timer_aux_irq_enable      <= 2'h0;
		end else begin
			capture_or_compare_select <= pulse_accum_control[`PACC_CTL_ICSEL];
			prescale_sel              <= timer_irq_mask_two[`PACC_MASK2_PR_LO +: 2];
			rti_rate_sel              <= pulse_accum_control[`PACC_CTL_RTR_LO +: 2];
			timer_aux_irq_enable      <= timer_irq_mask_two[`PACC_MASK2_AUX_LO +: 2];
		end
	end

	// ----------------------------------------
	// Pin synchroniser and edge detect
	// ----------------------------------------
	logic pin_meta;
	logic pin_sync;
	logic pin_prev;
	logic pin_edge;
	logic pin_active;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
			pin_prev <= 1'b0;
		end else begin
			pin_meta <= accum_input_pin;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// Toggles faster than half the clock can merge in the synchroniser
	assign pin_edge   = (pin_prev ^ pin_sync) & (pin_sync == edge_polarity_select);
	assign pin_active = pin_sync ^ edge_polarity_select;

	// ----------------------------------------
	// Free-running gate tick
	// ----------------------------------------
	logic [PW-1:0] div_cnt;
	logic          gate_tick;

	assign gate_tick = (div_cnt == PW'(GATE_DIV - 1));

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			div_cnt <= '0;
		end else if (gate_tick) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= div_cnt + PW'(1);
		end
	end

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	logic count_inc;
	logic count_wrap;

	always_comb begin
		count_inc = 1'b0;
		if (accum_enable) begin
			unique case (accum_mode_select)
				PACC_MODE_EVENT: count_inc = pin_edge;
				PACC_MODE_GATED: count_inc = gate_tick & pin_active;
			endcase
		end
	end

	assign count_wrap = count_inc & ~wr_cnt & (pulse_count == 8'hff);

	// No reset: count survives a reset; a write beats an increment
	always_ff @(posedge clock) begin
		if (wr_cnt) begin
			pulse_count <= writedata[7:0];
		end else if (count_inc) begin
			pulse_count <= pulse_count + 8'h01;
		end
	end

	// ----------------------------------------
	// Flags and interrupt
	// ----------------------------------------
	logic clr_ovf;
	logic clr_edge;

	assign clr_ovf  = (wr_flag2 | wr_fclr) & writedata[`PACC_BIT_OVF];
	assign clr_edge = (wr_flag2 | wr_fclr) & writedata[`PACC_BIT_EDGE];

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			overflow_flag <= 1'b0;
		end else if (count_wrap) begin
			overflow_flag <= 1'b1;
		end else if (clr_ovf) begin
			overflow_flag <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			edge_flag <= 1'b0;
		end else if (accum_enable & pin_edge) begin
			edge_flag <= 1'b1;
		end else if (clr_edge) begin
			edge_flag <= 1'b0;
		end
	end

	assign irq = (overflow_flag & overflow_irq_enable) | (edge_flag & edge_irq_enable);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	property p_event_inc;
		(accum_enable && accum_mode_select == PACC_MODE_EVENT && pin_edge && !wr_cnt)
			|=> pulse_count == $past(pulse_count) + 8'h01;
	endproperty
	a_event_inc: assert property (p_event_inc) else $error("event edge not counted");

	property p_disabled_hold;
		(!accum_enable && !wr_cnt) |=> $stable(pulse_count);
	endproperty
	a_disabled_hold: assert property (p_disabled_hold) else $error("count moved while off");

	property p_gated_inhibit;
		(accum_mode_select == PACC_MODE_GATED && pin_sync == edge_polarity_select && !wr_cnt)
			|=> $stable(pulse_count);
	endproperty
	a_gated_inhibit: assert property (p_gated_inhibit) else $error("inhibited gate counted");

	property p_gated_tick;
		(accum_enable && accum_mode_select == PACC_MODE_GATED && pin_active && !wr_cnt)
			|=> (pulse_count != $past(pulse_count)) == $past(gate_tick);
	endproperty
	a_gated_tick: assert property (p_gated_tick) else $error("gated count off tick");

	property p_tick_period;
		gate_tick |=> !gate_tick [*2];
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("gate tick too frequent");

	property p_ovf_set;
		(count_inc && !wr_cnt && pulse_count == 8'hff) |=> overflow_flag && pulse_count == 8'h00;
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("rollover lost");

	property p_edge_flag;
		(accum_enable && pin_edge) |=> edge_flag;
	endproperty
	a_edge_flag: assert property (p_edge_flag) else $error("edge flag not set");

	property p_irq_level;
		##1 irq == ((overflow_flag && timer_irq_mask_two[5]) || (edge_flag && timer_irq_mask_two[4]));
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq mismatch");

	property p_ctl_reserved;
		(read && bus_ack && reg_idx == `PACC_IDX_CTL) |-> readdata[7] == 1'b0 && readdata[3] == 1'b0;
	endproperty
	a_ctl_reserved: assert property (p_ctl_reserved) else $error("reserved bit set");

	property p_cnt_write;
		wr_cnt |=> pulse_count == $past(writedata[7:0]);
	endproperty
	a_cnt_write: assert property (p_cnt_write) else $error("count write lost");

	property p_one_wait;
		(bus_req && waitrequest) |=> !waitrequest;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("wait too long");

	c_wrap: cover property (count_wrap);
	c_gated: cover property (accum_mode_select == PACC_MODE_GATED && count_inc);
	c_edge_clr_race: cover property (accum_enable && pin_edge && clr_edge);
	c_irq: cover property (irq);

endmodule

/* tb/pacc_pin_source.sv */
`timescale 1ns/1ps

// ----------------------------------------
// Pin source driving the accumulator input
// ----------------------------------------
module pacc_pin_source (
	// Clock
	input  wire logic clock,
	// Pin drive
	output logic      accum_input_pin
);
	initial begin
		accum_input_pin = 1'b0;
	end

	// Level held for at least two clocks
	task set_level(input logic v);
		@(posedge clock);
		accum_input_pin <= v;
		repeat (2) @(posedge clock);
	endtask

	// Full pulses, low to high to low
	task pulses(input int n);
		repeat (n) begin
			set_level(1'b1);
			set_level(1'b0);
		end
	endtask
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps

module testbench;
	logic        clock       = 1'b0;
	logic        sys_rst     = 1'b1;
	logic [7:0]  address     = 8'h00;
	logic        read        = 1'b0;
	logic        write       = 1'b0;
	logic [31:0] writedata   = 32'h00000000;
	logic [3:0]  byteenable  = 4'h0;
	logic [3:0]  lane        = 4'h1;
	logic [31:0] readdata;
	logic [31:0] rd;
	logic        waitrequest;
	logic        icsel;
	logic [1:0]  prescale_sel;
	logic [1:0]  rti_rate_sel;
	logic [1:0]  aux_en;
	logic        irq;
	wire         accum_input_pin;
	int          errors      = 0;
	int          num_checks  = 0;

	always #2.5 clock = ~clock;

	pacc_pin_source src (.clock(clock), .accum_input_pin(accum_input_pin));

	pacc_top #(.GATE_DIV(8)) uut (
		.clock(clock), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .accum_input_pin(accum_input_pin),
		.capture_or_compare_select(icsel), .prescale_sel(prescale_sel),
		.rti_rate_sel(rti_rate_sel), .timer_aux_irq_enable(aux_en), .irq(irq)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task test_done;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge clock);
		address    <= a;
		writedata  <= {24'h000000, d};
		byteenable <= lane;
		read       <= ~wr;
		write      <= wr;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		if (waitrequest !== 1'b0) begin
			errors++;
			test_done;
		end
		rd = readdata;
		read  <= 1'b0;
		write <= 1'b0;
	endtask

	task rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		check(name, rd, {24'h000000, exp});
	endtask

	task cycles(input int n);
		repeat (n) @(posedge clock);
	endtask

	// ----------------------------------------
	// Hang guard
	// ----------------------------------------
	initial begin
		repeat (50000) @(posedge clock);
		errors++;
		test_done;
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		rd_chk("mask_rst", 8'h90, 8'h00);
		rd_chk("ctl_rst", 8'h98, 8'h00);
		// Count starts unknown; give it a value before anything watches it
		bus(1'b1, 8'h9c, 8'h00);
		// Write with lane 0 disabled must not land
		lane = 4'h0;
		bus(1'b1, 8'h98, 8'h77);
		lane = 4'h1;
		rd_chk("ctl_lane_off", 8'h98, 8'h00);
		// Low address bits are ignored
		rd_chk("cnt_alias", 8'h9f, 8'h00);
		rd_chk("flag_rst", 8'h94, 8'h00);
		check("irq_rst", irq, 1'b0);
		// Register access and timer side copies
		bus(1'b1, 8'h98, 8'hff);
		rd_chk("ctl_rw", 8'h98, 8'h77);
		check("icsel_on", icsel, 1'b1);
		check("rti_sel", rti_rate_sel, 2'h3);
		bus(1'b1, 8'h98, 8'h7b);
		rd_chk("ctl_rw2", 8'h98, 8'h73);
		check("icsel_off", icsel, 1'b0);
		bus(1'b1, 8'h90, 8'hff);
		rd_chk("mask_rw", 8'h90, 8'hf3);
		check("prescale", prescale_sel, 2'h3);
		check("aux_en", aux_en, 2'h3);
		bus(1'b1, 8'h90, 8'h00);
		bus(1'b1, 8'hfc, 8'hff);
		rd_chk("unmapped", 8'hfc, 8'h00);
		// Disabled accumulator
		bus(1'b1, 8'h98, 8'h00);
		bus(1'b1, 8'h9c, 8'h10);
		src.pulses(3);
		cycles(8);
		rd_chk("dis_cnt", 8'h9c, 8'h10);
		rd_chk("dis_flag", 8'h94, 8'h00);
		// Event counting, both polarities, with rollover
		for (int e = 0; e < 2; e++) begin
			bus(1'b1, 8'h94, 8'h30);
			bus(1'b1, 8'h98, e ? 8'h50 : 8'h40);
			bus(1'b1, 8'h9c, 8'hfe);
			src.set_level(1'b1);
			cycles(8);
			rd_chk("evt_rise", 8'h9c, e ? 8'hff : 8'hfe);
			src.set_level(1'b0);
			cycles(8);
			rd_chk("evt_fall", 8'h9c, 8'hff);
			src.pulses(2);
			cycles(8);
			rd_chk("evt_roll", 8'h9c, 8'h01);
			rd_chk("evt_flags", 8'h94, 8'h30);
		end
		// Interrupt enable, masking and clearing
		check("irq_masked", irq, 1'b0);
		bus(1'b1, 8'h90, 8'h30);
		cycles(2);
		check("irq_on", irq, 1'b1);
		bus(1'b1, 8'h90, 8'h20);
		bus(1'b1, 8'ha0, 8'h10);
		cycles(2);
		check("irq_ovf", irq, 1'b1);
		rd_chk("flag_ovf", 8'h94, 8'h20);
		bus(1'b1, 8'h90, 8'h10);
		cycles(2);
		check("irq_off", irq, 1'b0);
		bus(1'b1, 8'h94, 8'h20);
		rd_chk("flag_clr", 8'h94, 8'h00);
		bus(1'b1, 8'h90, 8'h00);
		// Gated accumulation
		bus(1'b1, 8'h98, 8'h60);
		bus(1'b1, 8'h9c, 8'h00);
		cycles(64);
		rd_chk("gate_low", 8'h9c, 8'h00);
		src.set_level(1'b1);
		cycles(78);
		src.set_level(1'b0);
		cycles(8);
		bus(1'b0, 8'h9c, 8'h00);
		check("gate_cnt", rd >= 32'd9 && rd <= 32'd11, 1'b1);
		bus(1'b1, 8'h98, 8'h70);
		src.set_level(1'b1);
		bus(1'b1, 8'h9c, 8'h00);
		cycles(64);
		rd_chk("gate_high", 8'h9c, 8'h00);
		src.set_level(1'b0);
		cycles(38);
		bus(1'b0, 8'h9c, 8'h00);
		check("gate_cnt2", rd >= 32'd4 && rd <= 32'd6, 1'b1);
		// Reset in mid-run keeps the count
		bus(1'b1, 8'h98, 8'h00);
		bus(1'b1, 8'h9c, 8'h5a);
		sys_rst <= 1'b1;
		cycles(4);
		sys_rst <= 1'b0;
		rd_chk("rst_cnt", 8'h9c, 8'h5a);
		rd_chk("rst_ctl", 8'h98, 8'h00);
		test_done;
	end
endmodule
